// ---- core/gauge_pkg.sv ----
// Constants, register map and state types for the charge gauge logic.
// Assumes one 200 MHz core clock and an asynchronous active-low reset.
package gauge_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [6:0] SLAVE_ADDR = 7'h64;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic [7:0] ALERT_RESP_BYTE = {SLAVE_ADDR, 1'b0};
    // Register indices.
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_CONTROL = 3'h1;
    localparam logic [2:0] REG_CHARGE_MSB = 3'h2;
    localparam logic [2:0] REG_CHARGE_LSB = 3'h3;
    localparam logic [2:0] REG_HIGH_MSB = 3'h4;
    localparam logic [2:0] REG_HIGH_LSB = 3'h5;
    localparam logic [2:0] REG_LOW_MSB = 3'h6;
    localparam logic [2:0] REG_LOW_LSB = 3'h7;
    // Status bit positions.
    localparam int ST_ID = 7;
    localparam int ST_SATURATE = 5;
    localparam int ST_HIGH = 3;
    localparam int ST_LOW = 2;
    localparam int ST_VBAT = 1;
    localparam int ST_LOCKOUT = 0;
    localparam logic [7:0] ST_CLEARABLE = 8'h2F;
    localparam logic [7:0] ST_ALERT_MASK = 8'h2E;
    // Identity bit value is arbitrary.
    localparam logic ID_BIT_VALUE = 1'b0;
    // Control field positions.
    localparam int CT_VBAT_HI = 7;
    localparam int CT_VBAT_LO = 6;
    localparam int CT_PRESC_HI = 5;
    localparam int CT_PRESC_LO = 3;
    localparam int CT_PIN_HI = 2;
    localparam int CT_PIN_LO = 1;
    localparam int CT_SHUTDOWN = 0;
    localparam logic [1:0] PIN_DISABLED = 2'h0;
    localparam logic [1:0] PIN_CHARGE_DONE = 2'h1;
    localparam logic [1:0] PIN_ALERT = 2'h2;
    // Reset values.
    localparam logic [7:0] CONTROL_RESET = 8'h3C;
    localparam logic [15:0] CHARGE_RESET = 16'h7FFF;
    localparam logic [15:0] CHARGE_MAX = 16'hFFFF;
    localparam logic [15:0] CHARGE_MIN = 16'h0000;
    localparam logic [15:0] HIGH_RESET = 16'hFFFF;
    localparam logic [15:0] LOW_RESET = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Synchroniser lanes.
    localparam int NSYNC = 7;
    localparam int SY_SCL = 6;
    localparam int SY_SDA = 5;
    localparam int SY_RAMP = 4;
    localparam int SY_POL = 3;
    localparam int SY_PIN = 2;
    localparam int SY_VBAT = 1;
    localparam int SY_LOCK = 0;
    // Monitor lanes start low so no lockout is seen before real samples.
    localparam logic [NSYNC-1:0] SYNC_RESET = 7'h7C;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_WRITE = 3'b011,
        BUS_WRITE_ACK = 3'b100,
        BUS_READ = 3'b101,
        BUS_READ_ACK = 3'b110
    } bus_state_type;

    typedef struct packed {
        logic [NSYNC-1:0] sync1;
        logic [NSYNC-1:0] sync2;
        logic scl_prev;
        logic sda_prev;
        logic ramp_prev;
        bus_state_type bus;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic is_read;
        logic is_ara;
        logic have_ptr;
        logic [2:0] ptr;
        logic sda_oe;
        logic [7:0] control;
        logic [15:0] charge;
        logic [15:0] high;
        logic [15:0] low;
        logic [6:0] presc;
        logic [7:0] flags;
        logic alert;
    } gauge_state_type;
endpackage

// ---- core/coulomb_count_gauge_logic.sv ----
// Digital core of a coulomb counting gauge with a two-wire slave port.
// Assumes bus, ramp and supply monitor inputs are asynchronous levels.
`timescale 1ns/1ps
// Function
// [RQ1] Answer only at the fixed seven-bit slave address; the code also answers alert response reads while alert is set.
// [RQ2] Slave only: clock is input, data line open-drain bidirectional.
// [RQ3] Each ramp reversal steps prescaler up or down by polarity.
// [RQ4] Prescaler factor programmable from one to 128 reversals.
// [RQ5] Prescaler overflow adds one to charge, underflow subtracts one.
// [RQ6] Reset: counting on, mid-scale charge, limits open, alert, max factor.
// [RQ7] Charge is sixteen bits held in two byte registers.
// [RQ8] Compare charge with high and low limits, set matching flags.
// [RQ9] Alert mode: pin pulls low on alert, otherwise released.
// [RQ10] Alert asserts on any flag except identity and lockout bits.
// [RQ11] Status read clears flags whose condition is gone, except top bit.
// [RQ12] Charge saturates at ends without wrapping and sets saturate flag.
// [RQ13] Charge-done input high forces charge to maximum.
// [RQ14] Two-bit field selects pin function; alert mode after reset.
// [RQ15] Battery undervoltage sets a flag when selected limit crossed.
// [RQ16] Supply lockout sets flag, halts counting, keeps registers.
// [RQ17] Eight internal registers reachable over the serial port.
// [RQ18] Status register at address zero.
// [RQ19] Eight-bit control register at address one.
// [RQ20] Pin codes: 10 alert, 01 charge-done, 00 disabled; avoid 11.
// [RQ21] Prescaler factor is two to the power of the three-bit field.
// [RQ22] Asserted alert released only by the alert response procedure; the code also releases it when the pin mode becomes disabled or charge-done.
// [RQ23] Limit exceeded means strictly above high or strictly below low.
// [RQ24] Prescaler wraps both ways, producing overflow or underflow.
module coulomb_count_gauge_logic (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Two-wire serial bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Dual-purpose pin
    input wire logic i_alert_or_charge_done_pin,
    output logic o_alert_or_charge_done_pin_out,
    output logic o_alert_or_charge_done_pin_oe,
    // Analog front end
    input wire logic i_ramp_dir,
    input wire logic i_current_positive,
    input wire logic i_battery_low,
    input wire logic i_supply_low_lockout
);
    gauge_pkg::gauge_state_type state_reg;
    gauge_pkg::gauge_state_type state_next;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic reversal;
    logic count_en;
    logic [6:0] presc_top;
    logic presc_ovf;
    logic presc_unf;
    logic [7:0] cond;
    logic status_clear;
    logic host_charge_write;
    logic force_full;
    logic [1:0] pin_mode;

    function automatic logic [7:0] read_byte(
        input gauge_pkg::gauge_state_type s, input logic [2:0] idx);
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            gauge_pkg::REG_STATUS: begin
                r = s.flags & gauge_pkg::ST_CLEARABLE;
                r[gauge_pkg::ST_ID] = gauge_pkg::ID_BIT_VALUE;
            end
            gauge_pkg::REG_CONTROL: r = s.control;
            gauge_pkg::REG_CHARGE_MSB: r = s.charge[15:8];
            gauge_pkg::REG_CHARGE_LSB: r = s.charge[7:0];
            gauge_pkg::REG_HIGH_MSB: r = s.high[15:8];
            gauge_pkg::REG_HIGH_LSB: r = s.high[7:0];
            gauge_pkg::REG_LOW_MSB: r = s.low[15:8];
            gauge_pkg::REG_LOW_LSB: r = s.low[7:0];
        endcase
        return r;
    endfunction

    always_comb begin
        state_next = state_reg;
        status_clear = 1'b0;
        host_charge_write = 1'b0;
        pin_mode = state_reg.control[gauge_pkg::CT_PIN_HI:gauge_pkg::CT_PIN_LO];
        state_next.sync1 = {i_scl, i_sda, i_ramp_dir, i_current_positive,
            i_alert_or_charge_done_pin, i_battery_low, i_supply_low_lockout};
        state_next.sync2 = state_reg.sync1;
        state_next.scl_prev = state_reg.sync2[gauge_pkg::SY_SCL];
        state_next.sda_prev = state_reg.sync2[gauge_pkg::SY_SDA];
        state_next.ramp_prev = state_reg.sync2[gauge_pkg::SY_RAMP];
        scl_rise = state_reg.sync2[gauge_pkg::SY_SCL] & ~state_reg.scl_prev;
        scl_fall = ~state_reg.sync2[gauge_pkg::SY_SCL] & state_reg.scl_prev;
        bus_start = state_reg.sync2[gauge_pkg::SY_SCL] & state_reg.scl_prev
            & state_reg.sda_prev & ~state_reg.sync2[gauge_pkg::SY_SDA];
        bus_stop = state_reg.sync2[gauge_pkg::SY_SCL] & state_reg.scl_prev
            & ~state_reg.sda_prev & state_reg.sync2[gauge_pkg::SY_SDA];

        // Serial slave; the clock line is only ever sampled.
        if (bus_start) begin
            state_next.bus = gauge_pkg::BUS_ADDR;
            state_next.bitcnt = 4'h0;
            state_next.sda_oe = 1'b0;
        end else if (bus_stop) begin
            state_next.bus = gauge_pkg::BUS_IDLE;
            state_next.sda_oe = 1'b0;
        end else if (scl_rise) begin
            if (state_reg.bus == gauge_pkg::BUS_ADDR ||
                state_reg.bus == gauge_pkg::BUS_WRITE) begin
                state_next.shreg = {state_reg.shreg[6:0],
                    state_reg.sync2[gauge_pkg::SY_SDA]};
                state_next.bitcnt = state_reg.bitcnt + 4'h1;
            end else if (state_reg.bus == gauge_pkg::BUS_READ) begin
                state_next.bitcnt = state_reg.bitcnt + 4'h1;
            end else if (state_reg.bus == gauge_pkg::BUS_READ_ACK &&
                state_reg.sync2[gauge_pkg::SY_SDA]) begin
                state_next.bus = gauge_pkg::BUS_IDLE;
            end
        end else if (scl_fall) begin
            unique case (state_reg.bus)
                gauge_pkg::BUS_IDLE: begin
                end
                gauge_pkg::BUS_ADDR: begin
                    if (state_reg.bitcnt == gauge_pkg::BITS_PER_BYTE) begin
                        if (state_reg.shreg[7:1] == gauge_pkg::SLAVE_ADDR ||
                            (state_reg.shreg[7:1] ==
                            gauge_pkg::ALERT_RESP_ADDR && state_reg.shreg[0]
                            && state_reg.alert)) begin
                            state_next.bus = gauge_pkg::BUS_ADDR_ACK; // [RQ1]
                            state_next.sda_oe = 1'b1; // [RQ2]
                            state_next.is_read = state_reg.shreg[0];
                            state_next.is_ara = state_reg.shreg[7:1] ==
                                gauge_pkg::ALERT_RESP_ADDR;
                            state_next.have_ptr = 1'b0;
                        end else begin
                            state_next.bus = gauge_pkg::BUS_IDLE; // [RQ1]
                        end
                    end
                end
                gauge_pkg::BUS_ADDR_ACK, gauge_pkg::BUS_READ_ACK: begin
                    state_next.bitcnt = 4'h0;
                    if (state_reg.is_read) begin
                        state_next.bus = gauge_pkg::BUS_READ;
                        if (state_reg.is_ara) begin
                            state_next.shreg = gauge_pkg::ALERT_RESP_BYTE;
                        end else begin
                            state_next.shreg = read_byte(state_reg,
                                state_reg.ptr); // [RQ17]
                            status_clear = state_reg.ptr ==
                                gauge_pkg::REG_STATUS; // [RQ18]
                            state_next.ptr = state_reg.ptr + 3'h1;
                        end
                        state_next.sda_oe = ~state_next.shreg[7];
                    end else begin
                        state_next.bus = gauge_pkg::BUS_WRITE;
                        state_next.sda_oe = 1'b0;
                    end
                end
                gauge_pkg::BUS_WRITE: begin
                    if (state_reg.bitcnt == gauge_pkg::BITS_PER_BYTE) begin
                        state_next.bus = gauge_pkg::BUS_WRITE_ACK;
                        state_next.sda_oe = 1'b1;
                        state_next.have_ptr = 1'b1;
                        if (!state_reg.have_ptr) begin
                            state_next.ptr = state_reg.shreg[2:0];
                        end else begin
                            state_next.ptr = state_reg.ptr + 3'h1;
                            unique case (state_reg.ptr)
                                gauge_pkg::REG_STATUS: begin
                                end
                                gauge_pkg::REG_CONTROL:
                                    state_next.control = state_reg.shreg;
                                gauge_pkg::REG_CHARGE_MSB: begin
                                    state_next.charge[15:8] = state_reg.shreg;
                                    host_charge_write = 1'b1; // [RQ7]
                                end
                                gauge_pkg::REG_CHARGE_LSB: begin
                                    state_next.charge[7:0] = state_reg.shreg;
                                    host_charge_write = 1'b1; // [RQ7]
                                end
                                gauge_pkg::REG_HIGH_MSB:
                                    state_next.high[15:8] = state_reg.shreg;
                                gauge_pkg::REG_HIGH_LSB:
                                    state_next.high[7:0] = state_reg.shreg;
                                gauge_pkg::REG_LOW_MSB:
                                    state_next.low[15:8] = state_reg.shreg;
                                gauge_pkg::REG_LOW_LSB:
                                    state_next.low[7:0] = state_reg.shreg;
                            endcase
                        end
                    end
                end
                gauge_pkg::BUS_WRITE_ACK: begin
                    state_next.bus = gauge_pkg::BUS_WRITE;
                    state_next.bitcnt = 4'h0;
                    state_next.sda_oe = 1'b0;
                end
                gauge_pkg::BUS_READ: begin
                    if (state_reg.bitcnt == gauge_pkg::BITS_PER_BYTE) begin
                        state_next.bus = gauge_pkg::BUS_READ_ACK;
                        state_next.sda_oe = 1'b0;
                    end else begin
                        state_next.shreg = {state_reg.shreg[6:0], 1'b0};
                        state_next.sda_oe = ~state_reg.shreg[6];
                    end
                end
                default: state_next.bus = gauge_pkg::BUS_IDLE;
            endcase
        end

        // Counting halts in lockout or power down but keeps every value.
        count_en = ~state_reg.sync2[gauge_pkg::SY_LOCK] &
            ~state_reg.control[gauge_pkg::CT_SHUTDOWN]; // [RQ16]
        reversal = state_reg.sync2[gauge_pkg::SY_RAMP] ^ state_reg.ramp_prev;
        presc_top = 7'((8'h01 << state_reg.control[gauge_pkg::CT_PRESC_HI:
            gauge_pkg::CT_PRESC_LO]) - 8'h01); // [RQ4] [RQ21]
        presc_ovf = 1'b0;
        presc_unf = 1'b0;
        if (count_en && reversal) begin // [RQ3]
            if (state_reg.sync2[gauge_pkg::SY_POL]) begin
                if (state_reg.presc >= presc_top) begin
                    state_next.presc = 7'h00; // [RQ24]
                    presc_ovf = 1'b1;
                end else begin
                    state_next.presc = state_reg.presc + 7'h01;
                end
            end else begin
                if (state_reg.presc == 7'h00) begin
                    state_next.presc = presc_top; // [RQ24]
                    presc_unf = 1'b1;
                end else begin
                    state_next.presc = state_reg.presc - 7'h01;
                end
            end
        end

        cond = 8'h00;
        if (!host_charge_write) begin
            if (presc_ovf) begin // [RQ5]
                if (state_reg.charge == gauge_pkg::CHARGE_MAX) begin
                    cond[gauge_pkg::ST_SATURATE] = 1'b1; // [RQ12]
                end else begin
                    state_next.charge = state_reg.charge + 16'h0001;
                end
            end else if (presc_unf) begin // [RQ5]
                if (state_reg.charge == gauge_pkg::CHARGE_MIN) begin
                    cond[gauge_pkg::ST_SATURATE] = 1'b1; // [RQ12]
                end else begin
                    state_next.charge = state_reg.charge - 16'h0001;
                end
            end
        end
        // A full charger overrides both counting and host writes.
        force_full = pin_mode == gauge_pkg::PIN_CHARGE_DONE &&
            state_reg.sync2[gauge_pkg::SY_PIN]; // [RQ13] [RQ20]
        if (force_full) begin
            state_next.charge = gauge_pkg::CHARGE_MAX; // [RQ13]
        end

        cond[gauge_pkg::ST_HIGH] = state_reg.charge > state_reg.high; // [RQ23]
        cond[gauge_pkg::ST_LOW] = state_reg.charge < state_reg.low; // [RQ23]
        cond[gauge_pkg::ST_VBAT] = state_reg.sync2[gauge_pkg::SY_VBAT] &&
            state_reg.control[gauge_pkg::CT_VBAT_HI:gauge_pkg::CT_VBAT_LO]
            != 2'h0; // [RQ15]
        cond[gauge_pkg::ST_LOCKOUT] = state_reg.sync2[gauge_pkg::SY_LOCK];
        // A flag whose cause is still present survives the clearing read.
        state_next.flags = (cond | (status_clear ? 8'h00 : state_reg.flags))
            & gauge_pkg::ST_CLEARABLE; // [RQ8] [RQ11] [RQ16]

        // Alert latches on a newly raised flag and drops on the response.
        if (!state_reg.control[gauge_pkg::CT_PIN_HI]) begin
            state_next.alert = 1'b0; // [RQ14]
        end else if (|(cond & ~state_reg.flags & gauge_pkg::ST_ALERT_MASK))
            begin
            state_next.alert = 1'b1; // [RQ10]
        end else if (state_reg.is_ara && scl_fall &&
            state_reg.bus == gauge_pkg::BUS_READ_ACK) begin
            state_next.alert = 1'b0; // [RQ22]
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= '0;
            state_reg.sync1 <= gauge_pkg::SYNC_RESET;
            state_reg.sync2 <= gauge_pkg::SYNC_RESET;
            state_reg.scl_prev <= 1'b1;
            state_reg.sda_prev <= 1'b1;
            state_reg.ramp_prev <= gauge_pkg::SYNC_RESET[gauge_pkg::SY_RAMP];
            state_reg.bus <= gauge_pkg::BUS_IDLE;
            state_reg.control <= gauge_pkg::CONTROL_RESET; // [RQ6] [RQ19]
            state_reg.charge <= gauge_pkg::CHARGE_RESET; // [RQ6]
            state_reg.high <= gauge_pkg::HIGH_RESET; // [RQ6]
            state_reg.low <= gauge_pkg::LOW_RESET; // [RQ6]
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_sda_out = 1'b0; // [RQ2]
    assign o_sda_oe = state_reg.sda_oe;
    assign o_alert_or_charge_done_pin_out = 1'b0; // [RQ9]
    assign o_alert_or_charge_done_pin_oe = state_reg.alert; // [RQ9]

    a_addr_reject: assert property (@(posedge i_core_clk) // [RQ1]
        disable iff (!i_nrst) scl_fall && !bus_start && !bus_stop &&
        state_reg.bus == gauge_pkg::BUS_ADDR &&
        state_reg.bitcnt == gauge_pkg::BITS_PER_BYTE &&
        state_reg.shreg[7:1] != gauge_pkg::SLAVE_ADDR &&
        state_reg.shreg[7:1] != gauge_pkg::ALERT_RESP_ADDR
        |=> state_reg.bus == gauge_pkg::BUS_IDLE && !o_sda_oe)
        else $error("foreign address acknowledged");
    a_sda_on_fall: assert property (@(posedge i_core_clk) // [RQ2]
        disable iff (!i_nrst) $rose(o_sda_oe) |-> $past(scl_fall))
        else $error("data line driven outside clock low");
    a_presc_step: assert property (@(posedge i_core_clk) // [RQ3]
        disable iff (!i_nrst) count_en && reversal &&
        state_reg.sync2[gauge_pkg::SY_POL] && state_reg.presc < presc_top
        |=> state_reg.presc == $past(state_reg.presc) + 7'h01)
        else $error("prescaler did not step up");
    a_presc_wrap: assert property (@(posedge i_core_clk) // [RQ24]
        disable iff (!i_nrst) count_en && reversal && !force_full &&
        !state_reg.sync2[gauge_pkg::SY_POL] && state_reg.presc == 7'h00 &&
        !host_charge_write && state_reg.charge != gauge_pkg::CHARGE_MIN
        |=> state_reg.charge == $past(state_reg.charge) - 16'h0001)
        else $error("underflow did not decrement charge");
    a_charge_sat: assert property (@(posedge i_core_clk) // [RQ12]
        disable iff (!i_nrst) presc_ovf && !host_charge_write &&
        state_reg.charge == gauge_pkg::CHARGE_MAX
        |=> state_reg.charge == gauge_pkg::CHARGE_MAX &&
        state_reg.flags[gauge_pkg::ST_SATURATE])
        else $error("charge wrapped at maximum");
    a_charge_full: assert property (@(posedge i_core_clk) // [RQ13]
        disable iff (!i_nrst) force_full |=> state_reg.charge ==
        gauge_pkg::CHARGE_MAX)
        else $error("charge done did not fill counter");
    a_high_flag: assert property (@(posedge i_core_clk) // [RQ8]
        disable iff (!i_nrst) state_reg.charge > state_reg.high
        |=> state_reg.flags[gauge_pkg::ST_HIGH])
        else $error("high limit flag missing");
    a_read_clear: assert property (@(posedge i_core_clk) // [RQ11]
        disable iff (!i_nrst) status_clear && !cond[gauge_pkg::ST_HIGH]
        |=> !state_reg.flags[gauge_pkg::ST_HIGH])
        else $error("status read did not clear flag");
    a_lockout_hold: assert property (@(posedge i_core_clk) // [RQ16]
        disable iff (!i_nrst) state_reg.sync2[gauge_pkg::SY_LOCK]
        |=> state_reg.presc == $past(state_reg.presc) &&
        state_reg.flags[gauge_pkg::ST_LOCKOUT])
        else $error("counting during lockout");
    a_alert_mode: assert property (@(posedge i_core_clk) // [RQ9]
        disable iff (!i_nrst) o_alert_or_charge_done_pin_oe
        |-> $past(state_reg.control[gauge_pkg::CT_PIN_HI]))
        else $error("alert driven outside alert mode");
endmodule

// ---- tb/gauge_host_model.sv ----
// Bus master and battery charger model facing the gauge.
// Assumes the bench resolves the pulled-up data and pin wires.
`timescale 1ns/1ps
module gauge_host_model (
    // Wire level
    input wire logic i_sda,
    // Driven lines
    output logic o_scl,
    output logic o_sda_low,
    output logic o_chg_level,
    output logic o_chg_drive
);
    logic [7:0] acks;
    initial begin
        o_scl <= 1'b1;
        o_sda_low <= 1'b0;
        o_chg_level <= 1'b0;
        o_chg_drive <= 1'b0;
        acks = 8'h00;
    end
    // Data moves mid-low so it stays clear of both clock edges.
    task automatic bitx(input logic b, output logic r);
        #20 o_sda_low <= ~b;
        #20 o_scl <= 1'b1;
        #12 r = i_sda;
        #12 o_scl <= 1'b0;
    endtask
    task automatic start;
        #20 o_sda_low <= 1'b0;
        #20 o_scl <= 1'b1;
        #20 o_sda_low <= 1'b1;
        #20 o_scl <= 1'b0;
    endtask
    task automatic stop;
        #20 o_sda_low <= 1'b1;
        #20 o_scl <= 1'b1;
        #20 o_sda_low <= 1'b0;
        #40;
    endtask
    task automatic xb(input logic [7:0] t, input logic m,
        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(t[i], r[i]);
        bitx(m, a);
        acks = {acks[6:0], a};
    endtask
    task automatic wr(input logic [6:0] a, input logic [2:0] p,
        input logic [7:0] d);
        logic [7:0] x;
        start;
        xb({a, 1'b0}, 1'b1, x);
        xb({5'h00, p}, 1'b1, x);
        xb(d, 1'b1, x);
        stop;
    endtask
    // Alert response reads are acknowledged; register reads end on a NACK.
    task automatic rd(input logic [6:0] a, input logic [2:0] p,
        output logic [7:0] d);
        logic [7:0] x;
        if (a == gauge_pkg::SLAVE_ADDR) begin
            start;
            xb({a, 1'b0}, 1'b1, x);
            xb({5'h00, p}, 1'b1, x);
        end
        start;
        xb({a, 1'b1}, 1'b1, x);
        xb(8'hFF, a == gauge_pkg::SLAVE_ADDR, d);
        stop;
    endtask
    task automatic chg(input logic lv, input logic dr);
        o_chg_level <= lv;
        o_chg_drive <= dr;
    endtask
endmodule

// ---- tb/test_coulomb_count_gauge_logic.sv ----
// Self-checking bench for the charge gauge logic.
// Assumes the host model owns the bus and the charger output.
`timescale 1ns/1ps
module test_coulomb_count_gauge_logic;
    localparam logic [6:0] SA = gauge_pkg::SLAVE_ADDR;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic ramp = 1'b1;
    logic pol = 1'b1;
    logic batt = 1'b0;
    logic lock = 1'b0;
    logic scl, sda_low, chg_lvl, chg_drv, sda_oe, pin_oe, sda, pin;
    logic [7:0] d;
    logic [15:0] v;
    logic [2:0] k;
    integer seed = 72865;
    integer err_count = 0;
    integer total_checks = 0;
    assign sda = ~(sda_oe | sda_low);
    assign pin = pin_oe ? 1'b0 : (chg_drv ? chg_lvl : 1'b1);
    gauge_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
        .o_chg_level(chg_lvl), .o_chg_drive(chg_drv));
    coulomb_count_gauge_logic DUT (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(),
        .o_sda_oe(sda_oe), .i_alert_or_charge_done_pin(pin),
        .o_alert_or_charge_done_pin_out(),
        .o_alert_or_charge_done_pin_oe(pin_oe), .i_ramp_dir(ramp),
        .i_current_positive(pol), .i_battery_low(batt),
        .i_supply_low_lockout(lock));
    initial forever #2.5 i_core_clk = ~i_core_clk;
    function automatic logic [7:0] ctrl(input logic [1:0] vb,
        input logic [2:0] pk, input logic [1:0] pm);
        return {vb, pk, pm, 1'b0};
    endfunction
    function automatic logic [7:0] reset_value(input logic [2:0] p);
        case (p)
            3'h0: return {gauge_pkg::ID_BIT_VALUE, 7'h00};
            3'h1: return ctrl(2'h0, 3'h7, 2'h2);
            3'h2: return 8'h7F;
            3'h6, 3'h7: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [2:0] p, input logic [7:0] x);
        host.wr(SA, p, x);
    endtask
    task automatic r(input logic [2:0] p);
        host.rd(SA, p, d);
    endtask
    task automatic r16;
        r(3'h2);
        v[15:8] = d;
        r(3'h3);
        v[7:0] = d;
    endtask
    task automatic steps(input int n, input logic up);
        @(posedge i_core_clk) pol <= up;
        repeat (n) begin
            @(posedge i_core_clk) ramp <= ~ramp;
            repeat (3) @(posedge i_core_clk);
        end
        repeat (6) @(posedge i_core_clk);
    endtask
    task automatic print_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        r(3'h0);
        for (int p = 0; p < 8; p++) begin
            r(3'(p));
            chk(16'(d), 16'(reset_value(3'(p))));
        end
        host.wr(7'h65 ^ (7'($unsigned($random(seed))) & 7'h0A), 3'h1, 8'h00);
        chk(16'(host.acks[2]), 16'h1);
        r(3'h1);
        chk(16'(d), 16'h3C);
        for (int j = 0; j < 2; j++) begin
            k = j ? 3'h7 : 3'($unsigned($random(seed)));
            w(3'h1, ctrl(2'h0, k, 2'h2));
            w(3'h2, 8'h80);
            w(3'h3, 8'h00);
            steps(1 << k, 1'b1);
            r16;
            chk(v, 16'h8001);
            steps(1, 1'b0);
            r16;
            chk(v, 16'h8000);
            steps(1, 1'b1);
        end
        w(3'h1, ctrl(2'h0, 3'h0, 2'h2));
        w(3'h2, 8'hFF);
        w(3'h3, 8'hFE);
        steps(3, 1'b1);
        r16;
        chk(v, 16'hFFFF);
        chk(16'(pin_oe), 16'h1);
        r(3'h0);
        chk(16'(d), 16'h20);
        r(3'h0);
        chk(16'(d), 16'h00);
        chk(16'(pin_oe), 16'h1);
        host.rd(gauge_pkg::ALERT_RESP_ADDR, 3'h0, d);
        chk({8'h00, d}, {8'h00, SA, 1'b0});
        chk(16'(pin_oe), 16'h0);
        w(3'h5, 8'hFE);
        r(3'h0);
        chk(16'(d), 16'h08);
        w(3'h5, 8'hFF);
        host.rd(gauge_pkg::ALERT_RESP_ADDR, 3'h0, d);
        r(3'h0);
        w(3'h1, ctrl(2'h1, 3'h0, 2'h2));
        @(posedge i_core_clk) lock <= 1'b1;
        steps(4, 1'b0);
        r16;
        chk(v, 16'hFFFF);
        r(3'h0);
        chk({d, 7'h00, pin_oe}, 16'h0100);
        @(posedge i_core_clk) lock <= 1'b0;
        batt <= 1'b1;
        steps(2, 1'b0);
        r16;
        chk(v, 16'hFFFD);
        r(3'h0);
        chk({d, 7'h00, pin_oe}, 16'h0301);
        @(posedge i_core_clk) batt <= 1'b0;
        host.chg(1'b0, 1'b1);
        w(3'h1, ctrl(2'h0, 3'h0, 2'h1));
        host.chg(1'b1, 1'b1);
        repeat (8) @(posedge i_core_clk);
        r16;
        chk({v[15:1], pin_oe}, 16'hFFFE);
        w(3'h1, ctrl(2'h0, 3'h0, 2'h0));
        w(3'h2, 8'h12);
        w(3'h3, 8'h34);
        r16;
        chk(v, 16'h1234);
        w(3'h6, 8'h13);
        r(3'h0);
        chk(16'(d), 16'h06);
        host.chg(1'b0, 1'b0);
        print_verdict;
    end
endmodule
